/* File: core/cir_core.sv */
// CAN interrupt, flag, mode handshake and bus-off recovery logic
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cir_core import cir_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [5:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [5:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic RX_FRONT_LOAD,
  input wire logic RX_OVERRUN,
  input wire logic [2:0] TX_BUF_DONE,
  input wire logic [8:0] TX_ERR_CNT,
  input wire logic [7:0] RX_ERR_CNT,
  input wire logic BUS_IDLE,
  input wire logic CAN_RX,
  input wire logic PWR_DOWN,
  output logic IRQ_WAKE,
  output logic IRQ_ERR,
  output logic IRQ_RX,
  output logic IRQ_TX,
  output logic IRQ,
  output logic WAKE_STOP_REQ,
  output logic BUS_RECOVER,
  output logic BUS_OFF
);
  typedef struct packed {
    logic awready;
    logic [5:0] aw_addr;
    logic wready;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [DIV_W-1:0] div;
    logic tick;
    cir_mode_t mode;
    logic [1:0] init_stage;
    logic init_req;
    logic sleep_req;
    logic wake_en;
    logic moden;
    logic recov_sel;
    logic bo_hold;
    logic rx_full;
    logic ovr;
    logic csc;
    logic wup;
    logic [1:0] tx_state;
    logic [1:0] rx_state;
    logic [3:0] rier;
    logic [2:0] tflg;
    logic [2:0] tier;
    logic busoff;
    logic tx_hi;
    logic [4:0] evt;
    logic [4:0] evt_mask;
    logic slept;
    logic pwr_prev;
    logic irq_wake;
    logic irq_err;
    logic irq_rx;
    logic irq_tx;
    logic irq;
    logic wake_stop;
    logic recover;
  } cir_core_st_t;

  cir_core_st_t q, d;
  logic rx_s;
  logic bo_done;
  logic en;
  logic wr;
  logic rd;
  logic rx_set;
  logic ovr_set;
  logic csc_set;
  logic wup_set;
  logic wake_go;
  logic rec_ok;
  logic rec_go;
  logic [2:0] tx_set;
  logic [3:0] rflg_wr1;
  logic [1:0] tx_new;
  logic [1:0] rx_new;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // ****************************************
  // Helpers
  // ****************************************
  cir_sync u_rx_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .din(CAN_RX),
    .dout(rx_s)
  );

  cir_busoff_count u_busoff (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .tick(q.tick),
    .rx(rx_s),
    .busoff(q.busoff),
    .count_en(q.mode == CIR_RUN && q.moden),
    .done(bo_done)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (ARADDR)
      OFS_CTL0: begin
        rd_word[CTL0_SETUP_REQ] = q.init_req;
        rd_word[CTL0_SLEEP_REQ] = q.sleep_req;
        rd_word[CTL0_WAKE_EN] = q.wake_en;
        rd_word[CTL0_SETUP_ACK] = (q.mode == CIR_SETUP);
        rd_word[CTL0_SLEEP_ACK] = (q.mode == CIR_SLEEP);
      end
      OFS_CTL1: begin
        rd_word[CTL1_MODEN] = q.moden;
        rd_word[CTL1_RECOV_SEL] = q.recov_sel;
      end
      OFS_RFLG: begin
        rd_word[3:0] = {q.wup, q.csc, q.ovr, q.rx_full};
        rd_word[FLG_TX_STATE+:2] = q.tx_state;
        rd_word[FLG_RX_STATE+:2] = q.rx_state;
      end
      OFS_RIER: rd_word[3:0] = q.rier;
      OFS_TFLG: rd_word[2:0] = q.tflg;
      OFS_TIER: rd_word[2:0] = q.tier;
      OFS_MISC: rd_word[MISC_BO_HOLD] = q.bo_hold;
      OFS_EVT: rd_word[4:0] = q.evt;
      OFS_EVT_MASK: rd_word[4:0] = q.evt_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (q.aw_addr)
      OFS_CTL0, OFS_CTL1, OFS_RFLG, OFS_RIER, OFS_TFLG: wr_hit = 1'b1;
      OFS_TIER, OFS_MISC, OFS_EVT, OFS_EVT_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.recover = 1'b0;
    wr = !q.awready && !q.wready && !q.bvalid;
    rd = ARVALID && q.arready;
    en = q.moden && (q.mode != CIR_SETUP);
    // Bus handshakes
    if (AWVALID && q.awready) begin
      d.awready = 1'b0;
      d.aw_addr = AWADDR;
    end
    if (WVALID && q.wready) begin
      d.wready = 1'b0;
      d.w_data = WDATA;
      d.w_lane0 = WSTRB[0];
    end
    if (wr) begin
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && BREADY) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (rd) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rd_word;
      d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && RREADY) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    wr = wr && q.w_lane0;
    // Bit-time enable
    d.tick = 1'b0;
    if (q.div == DIV_W'(BIT_CYC - 1)) begin
      d.div = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 1'b1;
    end
    // Bus states from error counters
    if (q.busoff) begin
      tx_new = ST_BUSOFF;
    end else if (TX_ERR_CNT >= TX_PASSIVE_LIM) begin
      tx_new = ST_PASSIVE;
    end else if (TX_ERR_CNT >= TX_WARN_LIM) begin
      tx_new = ST_WARN;
    end else begin
      tx_new = ST_OK;
    end
    if (RX_ERR_CNT >= RX_PASSIVE_LIM) begin
      rx_new = ST_PASSIVE;
    end else if (RX_ERR_CNT >= RX_WARN_LIM) begin
      rx_new = ST_WARN;
    end else begin
      rx_new = ST_OK;
    end
    csc_set = en && ((tx_new != q.tx_state) || (rx_new != q.rx_state));
    d.tx_state = tx_new;
    d.rx_state = rx_new;
    // Bus-off entry and recovery
    d.tx_hi = TX_ERR_CNT[8];
    if (TX_ERR_CNT[8] && !q.tx_hi && !q.busoff) begin
      d.busoff = 1'b1;
    end
    rec_ok = !q.recov_sel || !q.bo_hold;
    rec_go = q.busoff && bo_done && rec_ok;
    if (rec_go) begin
      d.busoff = 1'b0;
      d.recover = 1'b1;
    end
    // Register writes
    rflg_wr1 = '0;
    if (wr) begin
      unique case (q.aw_addr)
        OFS_CTL0: begin
          if (q.w_data[CTL0_SETUP_REQ] || q.mode == CIR_SETUP) begin
            d.init_req = q.w_data[CTL0_SETUP_REQ];
          end
          if (q.w_data[CTL0_SLEEP_REQ] || q.mode == CIR_SLEEP) begin
            d.sleep_req = q.w_data[CTL0_SLEEP_REQ];
          end
          d.wake_en = q.w_data[CTL0_WAKE_EN];
        end
        OFS_CTL1: begin
          d.moden = q.w_data[CTL1_MODEN];
          d.recov_sel = q.w_data[CTL1_RECOV_SEL];
        end
        OFS_RFLG: rflg_wr1 = q.w_data[3:0];
        OFS_RIER: d.rier = q.w_data[3:0];
        OFS_TIER: d.tier = q.w_data[2:0];
        OFS_MISC: d.bo_hold = q.bo_hold && !q.w_data[MISC_BO_HOLD];
        OFS_EVT_MASK: d.evt_mask = q.w_data[4:0];
        default: d.evt_mask = q.evt_mask;
      endcase
    end
    if (d.busoff && !q.busoff) begin
      d.bo_hold = q.recov_sel;
    end
    // Mode handshake
    d.init_stage = {q.init_stage[0], q.init_req};
    wake_go = (q.mode == CIR_SLEEP) && q.wake_en && !rx_s;
    wup_set = wake_go && q.moden;
    unique case (q.mode)
      CIR_RUN: begin
        if (q.init_req && q.init_stage[1]) begin
          d.mode = CIR_SETUP;
        end else if (q.sleep_req && BUS_IDLE) begin
          d.mode = CIR_SLEEP;
        end
      end
      CIR_SLEEP: begin
        if (q.init_req && q.init_stage[1]) begin
          d.mode = CIR_SETUP;
        end else if (!d.sleep_req) begin
          d.mode = CIR_RUN;
        end else if (wake_go) begin
          d.mode = CIR_RUN;
          d.sleep_req = 1'b0;
        end
      end
      CIR_SETUP: begin
        d.sleep_req = 1'b0;
        if (!q.init_req) begin
          d.mode = CIR_RUN;
        end
      end
      default: d.mode = CIR_RUN;
    endcase
    // Flags: set wins over clear
    rx_set = en && (q.mode == CIR_RUN) && RX_FRONT_LOAD;
    ovr_set = en && RX_OVERRUN;
    tx_set = {3{en}} & TX_BUF_DONE;
    d.rx_full = rx_set || (q.rx_full && !rflg_wr1[FLG_RX_FULL]);
    d.ovr = ovr_set || (q.ovr && !rflg_wr1[FLG_OVR]);
    d.csc = csc_set || (q.csc && !rflg_wr1[FLG_CSC]);
    d.wup = wup_set || (q.wup && !rflg_wr1[FLG_WUP]);
    if (wr && q.aw_addr == OFS_TFLG) begin
      d.tflg = tx_set | (q.tflg & ~q.w_data[2:0]);
    end else begin
      d.tflg = tx_set | q.tflg;
    end
    if (q.mode == CIR_SETUP) begin
      d.rx_full = 1'b0;
      d.ovr = 1'b0;
      d.csc = 1'b0;
      d.wup = 1'b0;
      d.rier = '0;
      d.tflg = '0;
      d.tier = '0;
    end
    // Sticky events, cleared by reading
    d.evt = {d.recover, |tx_set, csc_set || ovr_set, wup_set, rx_set};
    d.evt = d.evt | ((rd && ARADDR == OFS_EVT) ? 5'h00 : q.evt);
    // Power-down wake
    d.pwr_prev = PWR_DOWN;
    if (!PWR_DOWN) begin
      d.slept = 1'b0;
    end else if (!q.pwr_prev) begin
      d.slept = (q.mode == CIR_SLEEP);
    end
    d.wake_stop = PWR_DOWN && d.slept && d.wake_en && d.rier[FLG_WUP] && d.wup;
    // Requests
    d.irq_wake = d.wup && d.rier[FLG_WUP];
    d.irq_err = (d.csc && d.rier[FLG_CSC]) || (d.ovr && d.rier[FLG_OVR]);
    d.irq_rx = d.rx_full && d.rier[FLG_RX_FULL];
    d.irq_tx = |(d.tflg & d.tier);
    d.irq = |(d.evt & d.evt_mask);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.mode <= CIR_SETUP;
      q.init_req <= RST_INIT_REQ;
      q.init_stage <= RST_INIT_STAGE;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AWREADY = q.awready;
  assign WREADY = q.wready;
  assign BVALID = q.bvalid;
  assign BRESP = q.bresp;
  assign ARREADY = q.arready;
  assign RVALID = q.rvalid;
  assign RDATA = q.rdata;
  assign RRESP = q.rresp;
  assign IRQ_WAKE = q.irq_wake;
  assign IRQ_ERR = q.irq_err;
  assign IRQ_RX = q.irq_rx;
  assign IRQ_TX = q.irq_tx;
  assign IRQ = q.irq;
  assign WAKE_STOP_REQ = q.wake_stop;
  assign BUS_RECOVER = q.recover;
  assign BUS_OFF = q.busoff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  chk_rx_full_set: assert property (rx_set |=> q.rx_full)
    else $error("receive flag not set after load");
  chk_clear_blocked: assert property (rx_set && rflg_wr1[FLG_RX_FULL] |=> q.rx_full)
    else $error("receive flag cleared while load present");
  chk_w1c_rx_full: assert property (rflg_wr1[FLG_RX_FULL] && !rx_set |=> !q.rx_full)
    else $error("receive flag not cleared by one");
  chk_wake_gate: assert property ($rose(q.wup) |-> $past(q.wake_en) && $past(wake_go))
    else $error("wake flag without enable in sleep");
  chk_irq_err: assert property (IRQ_ERR == ((q.csc && q.rier[FLG_CSC]) ||
      (q.ovr && q.rier[FLG_OVR])))
    else $error("error request mismatch");
  chk_csc_set: assert property (csc_set |=> q.csc ##1 q.csc || rflg_wr1[FLG_CSC] ||
      q.mode == CIR_SETUP)
    else $error("status change not flagged");
  chk_sleep_hs: assert property (q.mode == CIR_SLEEP |-> q.sleep_req)
    else $error("sleep ack without request");
  chk_init_ack: assert property ($rose(q.mode == CIR_SETUP) |->
      $past(q.init_req) && $past(q.init_req, 3))
    else $error("setup ack before handshake");
  chk_recover_gate: assert property (BUS_RECOVER |-> $past(rec_ok) && !q.busoff)
    else $error("recovery while hold set");
  chk_wake_stop: assert property (WAKE_STOP_REQ |-> q.slept && q.wup)
    else $error("power-down wake without prior sleep");
  chk_leave_sleep: assert property ($fell(q.mode == CIR_SLEEP) |->
      $past(wake_go) || !q.sleep_req || $past(q.init_req))
    else $error("sleep left without cause");

  cov_rx_load: cover property (rx_set ##1 IRQ_RX);
  cov_wake: cover property (wup_set);
  cov_recover: cover property (BUS_RECOVER);
  cov_setup_exit: cover property ($fell(q.mode == CIR_SETUP));
endmodule
`default_nettype wire

/* File: include/cir_pkg.sv */
// Constants and types for the CAN interrupt and bus-off recovery block
// Overview of operation
// - Set receive-full when message reaches front buffer
// - Set receive-full again for each queued message
// - Bus activity in sleep raises wake-up if enabled
// - Overrun or bus state change raises error event
// - Flag status change, report tx/rx states separately
// - Request pending while any of its flags set
// - Writing one clears a flag, zero keeps it
// - Clear ignored while setting condition still present
// - Wake ends power-down only after sleep, enables set
// - Default recovery after 128 runs of 11 recessive
// - Selected mode also waits for hold bit cleared
// - Four separately enabled requests: wake, error, rx, tx
// - Sleep active shown by request and acknowledge set
// - Setup acknowledge only after all stages entered setup
// - Leave sleep on enabled bus activity or request clear
package cir_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_TIME_NS = 2000;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = $clog2(BIT_CYC);
  localparam int RECESSIVE_RUN = 11;
  localparam int RECOVERY_RUNS = 128;
  localparam logic [3:0] RUN_LAST = 4'(RECESSIVE_RUN - 1);
  localparam logic [7:0] OCC_DONE = 8'(RECOVERY_RUNS);
  localparam logic [8:0] TX_WARN_LIM = 9'h060;
  localparam logic [8:0] TX_PASSIVE_LIM = 9'h080;
  localparam logic [7:0] RX_WARN_LIM = 8'h60;
  localparam logic [7:0] RX_PASSIVE_LIM = 8'h80;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] OFS_CTL0 = 6'h00;
  localparam logic [5:0] OFS_CTL1 = 6'h04;
  localparam logic [5:0] OFS_RFLG = 6'h08;
  localparam logic [5:0] OFS_RIER = 6'h0c;
  localparam logic [5:0] OFS_TFLG = 6'h10;
  localparam logic [5:0] OFS_TIER = 6'h14;
  localparam logic [5:0] OFS_MISC = 6'h18;
  localparam logic [5:0] OFS_EVT = 6'h1c;
  localparam logic [5:0] OFS_EVT_MASK = 6'h20;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL0_SETUP_REQ = 0;
  localparam int CTL0_SLEEP_REQ = 1;
  localparam int CTL0_WAKE_EN = 2;
  localparam int CTL0_SETUP_ACK = 8;
  localparam int CTL0_SLEEP_ACK = 9;
  localparam int CTL1_MODEN = 0;
  localparam int CTL1_RECOV_SEL = 1;
  localparam int FLG_RX_FULL = 0;
  localparam int FLG_OVR = 1;
  localparam int FLG_CSC = 2;
  localparam int FLG_WUP = 3;
  localparam int FLG_TX_STATE = 4;
  localparam int FLG_RX_STATE = 6;
  localparam int MISC_BO_HOLD = 0;
  localparam int EVT_RX = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_ERR = 2;
  localparam int EVT_TX = 3;
  localparam int EVT_RECOVER = 4;
  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_PASSIVE = 2'h2;
  localparam logic [1:0] ST_BUSOFF = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic RST_INIT_REQ = 1'h1;
  localparam logic [1:0] RST_INIT_STAGE = 2'h3;
  localparam logic RST_CAN_RX = 1'h1;
  typedef enum logic [2:0] {
    CIR_RUN = 3'h1,
    CIR_SLEEP = 3'h2,
    CIR_SETUP = 3'h4
  } cir_mode_t;
endpackage

/* File: core/cir_sync.sv */
// Two-stage synchroniser for the bus receive pin
`timescale 1ns/1ps
`default_nettype none
module cir_sync import cir_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } cir_sync_st_t;
  cir_sync_st_t q, d;
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= {RST_CAN_RX, RST_CAN_RX};
    end else begin
      q <= d;
    end
  end
  assign dout = q.s2;
endmodule
`default_nettype wire

/* File: core/cir_busoff_count.sv */
// Counter of recessive-bit runs for leaving bus-off
`timescale 1ns/1ps
`default_nettype none
module cir_busoff_count import cir_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic rx,
  input wire logic busoff,
  input wire logic count_en,
  output logic done
);
  typedef struct packed {
    logic [3:0] run;
    logic [7:0] occ;
  } cir_bo_st_t;
  cir_bo_st_t q, d;
  always_comb begin
    d = q;
    if (!busoff) begin
      d = '0;
    end else if (count_en && tick) begin
      if (!rx) begin
        d.run = '0;
      end else if (q.run == RUN_LAST) begin
        d.run = '0;
        if (q.occ != OCC_DONE) begin
          d.occ = q.occ + 1'b1;
        end
      end else begin
        d.run = q.run + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign done = (q.occ == OCC_DONE);
endmodule
`default_nettype wire

/* File: sim/cir_node_model.sv */
// Model of another node on the CAN bus
`timescale 1ns/1ps
`default_nettype none
module cir_node_model (
  input wire logic clk,
  input wire logic send,
  output logic can_rx
);
  logic [3:0] dom_q = 4'h0;
  // ****************************************
  // Bus level
  // ****************************************
  // Recessive when idle, dominant burst on request
  always_ff @(posedge clk) begin
    if (send) begin
      dom_q <= 4'h8;
    end else if (dom_q != 4'h0) begin
      dom_q <= dom_q - 4'h1;
    end
  end
  assign can_rx = (dom_q == 4'h0);
endmodule
`default_nettype wire

/* File: sim/cir_core_test.sv */
// Self-checking bench for the CAN interrupt and bus-off block
`timescale 1ns/1ps
`default_nettype none
module cir_core_test import cir_pkg::*;;
  logic SYS_CLK = 1'h0;
  logic RESET_N = 1'h0;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [5:0] AWADDR = 6'h00, ARADDR = 6'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic RX_FRONT_LOAD = 1'h0, RX_OVERRUN = 1'h0, BUS_IDLE = 1'h0, PWR_DOWN = 1'h0;
  logic send = 1'h0;
  logic [2:0] TX_BUF_DONE = 3'h0;
  logic [8:0] TX_ERR_CNT = 9'h000;
  logic [7:0] RX_ERR_CNT = 8'h00;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CAN_RX;
  logic IRQ_WAKE, IRQ_ERR, IRQ_RX, IRQ_TX, IRQ, WAKE_STOP_REQ, BUS_RECOVER, BUS_OFF;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  cir_core dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RX_FRONT_LOAD(RX_FRONT_LOAD), .RX_OVERRUN(RX_OVERRUN), .TX_BUF_DONE(TX_BUF_DONE),
    .TX_ERR_CNT(TX_ERR_CNT), .RX_ERR_CNT(RX_ERR_CNT), .BUS_IDLE(BUS_IDLE), .CAN_RX(CAN_RX),
    .PWR_DOWN(PWR_DOWN), .IRQ_WAKE(IRQ_WAKE), .IRQ_ERR(IRQ_ERR), .IRQ_RX(IRQ_RX),
    .IRQ_TX(IRQ_TX), .IRQ(IRQ), .WAKE_STOP_REQ(WAKE_STOP_REQ), .BUS_RECOVER(BUS_RECOVER),
    .BUS_OFF(BUS_OFF));
  cir_node_model node (.clk(SYS_CLK), .send(send), .can_rx(CAN_RX));

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] resp = RESP_OKAY);
    @(posedge SYS_CLK);
    AWVALID <= 1'h1;
    AWADDR <= a;
    WVALID <= 1'h1;
    WDATA <= d;
    WSTRB <= 4'hf;
    BREADY <= 1'h1;
    do begin
      @(posedge SYS_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
    end while (BVALID !== 1'h1);
    BREADY <= 1'h0;
    chk(32'(BRESP), 32'(resp));
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp,
                     input logic [1:0] resp = RESP_OKAY);
    @(posedge SYS_CLK);
    ARVALID <= 1'h1;
    ARADDR <= a;
    RREADY <= 1'h1;
    do begin
      @(posedge SYS_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
    end while (RVALID !== 1'h1);
    RREADY <= 1'h0;
    chk(RDATA, exp);
    chk(32'(RRESP), 32'(resp));
  endtask
  // One-cycle event pulse: {tx done[2:0], overrun, rx load}
  task automatic pulse(input logic [4:0] v);
    @(posedge SYS_CLK) {TX_BUF_DONE, RX_OVERRUN, RX_FRONT_LOAD} <= v;
    @(posedge SYS_CLK) {TX_BUF_DONE, RX_OVERRUN, RX_FRONT_LOAD} <= 5'h00;
    tick(3);
  endtask
  task automatic bump;
    @(posedge SYS_CLK) send <= 1'h1;
    @(posedge SYS_CLK) send <= 1'h0;
    tick(14);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(10);
    RESET_N <= 1'h1;
    tick(1);
    chk(32'({IRQ_WAKE, IRQ_ERR, IRQ_RX, IRQ_TX, IRQ, WAKE_STOP_REQ, BUS_OFF}), 32'h0);
    rdc(OFS_CTL0, 32'h101);
    rdc(6'h24, 32'h0, RESP_SLVERR);
    wr(6'h24, 32'h1, RESP_SLVERR);
    wr(OFS_CTL1, 32'h1);
    wr(OFS_CTL0, 32'h0);
    tick(4);
    rdc(OFS_CTL0, 32'h0);
    wr(OFS_RIER, 32'hf);
    wr(OFS_TIER, 32'h7);
    wr(OFS_EVT_MASK, 32'h1f);
    // Receive flag, acknowledge, re-set and clear while held
    pulse(5'h01);
    chk(IRQ_RX, 1'h1);
    chk(IRQ, 1'h1);
    rdc(OFS_RFLG, 32'h1);
    rdc(OFS_EVT, 32'h1);
    rdc(OFS_EVT, 32'h0);
    wr(OFS_RFLG, 32'h0);
    rdc(OFS_RFLG, 32'h1);
    wr(OFS_RFLG, 32'h1);
    tick(2);
    chk(IRQ_RX, 1'h0);
    pulse(5'h01);
    rdc(OFS_RFLG, 32'h1);
    @(posedge SYS_CLK) RX_FRONT_LOAD <= 1'h1;
    wr(OFS_RFLG, 32'h1);
    @(posedge SYS_CLK) RX_FRONT_LOAD <= 1'h0;
    rdc(OFS_RFLG, 32'h1);
    wr(OFS_RFLG, 32'h1);
    rdc(OFS_RFLG, 32'h0);
    // Activity while running wakes nothing
    @(posedge SYS_CLK) PWR_DOWN <= 1'h1;
    bump();
    chk(WAKE_STOP_REQ, 1'h0);
    rdc(OFS_RFLG, 32'h0);
    @(posedge SYS_CLK) PWR_DOWN <= 1'h0;
    // Sleep and wake by bus activity
    @(posedge SYS_CLK) BUS_IDLE <= 1'h1;
    wr(OFS_CTL0, 32'h6);
    tick(3);
    rdc(OFS_CTL0, 32'h206);
    bump();
    rdc(OFS_CTL0, 32'h4);
    rdc(OFS_RFLG, 32'h8);
    chk(IRQ_WAKE, 1'h1);
    wr(OFS_RFLG, 32'h8);
    // Wake out of power-down after sleep
    wr(OFS_CTL0, 32'h6);
    tick(3);
    @(posedge SYS_CLK) PWR_DOWN <= 1'h1;
    tick(2);
    bump();
    chk(WAKE_STOP_REQ, 1'h1);
    @(posedge SYS_CLK) PWR_DOWN <= 1'h0;
    wr(OFS_RFLG, 32'h8);
    // Leave sleep by clearing the request
    wr(OFS_CTL0, 32'h6);
    tick(3);
    wr(OFS_CTL0, 32'h4);
    rdc(OFS_CTL0, 32'h4);
    rdc(OFS_RFLG, 32'h0);
    // Error counters and overrun
    @(posedge SYS_CLK) TX_ERR_CNT <= 9'h060;
    tick(3);
    rdc(OFS_RFLG, 32'h14);
    chk(IRQ_ERR, 1'h1);
    pulse(5'h02);
    rdc(OFS_RFLG, 32'h16);
    wr(OFS_RFLG, 32'h2);
    tick(2);
    chk(IRQ_ERR, 1'h1);
    @(posedge SYS_CLK) RX_ERR_CNT <= 8'h80;
    tick(3);
    rdc(OFS_RFLG, 32'h94);
    // Transmit flags
    pulse(5'h14);
    rdc(OFS_TFLG, 32'h5);
    chk(IRQ_TX, 1'h1);
    wr(OFS_TFLG, 32'h1);
    rdc(OFS_TFLG, 32'h4);
    // Bus-off held for software release
    wr(OFS_CTL1, 32'h3);
    @(posedge SYS_CLK) TX_ERR_CNT <= 9'h100;
    tick(3);
    chk(BUS_OFF, 1'h1);
    rdc(OFS_RFLG, 32'hb4);
    rdc(OFS_MISC, 32'h1);
    wr(OFS_MISC, 32'h1);
    rdc(OFS_MISC, 32'h0);
    chk(32'({BUS_OFF, BUS_RECOVER}), 32'h2);
    // Back to setup for reconfiguration
    wr(OFS_CTL0, 32'h3);
    tick(4);
    rdc(OFS_CTL0, 32'h101);
    rdc(OFS_RIER, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
